/* hdl/omc_array.sv */
// Output macrocell array in simple and combinatorial I/O modes.
// Assumes inputs synchronous to clk_i; pins are split into in, out and enable.
`timescale 1ns/100ps
`include "omc_regs.svh"
module omc_array #(
  parameter int CELLS  = `OMC_CELLS,
  parameter int NTERMS = `OMC_TERMS_SIMPLE
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      nrst_i,
  // Configuration bits
  input  wire logic                      global_sync_select_bit_i,
  input  wire logic                      global_arch_select_bit_i,
  input  wire logic [CELLS-1:0]          polarity_i,
  input  wire logic [CELLS-1:0]          cell_direction_bit_i,
  input  wire logic [`OMC_SIG_BITS-1:0]  user_signature_fuses_i,
  // Evaluated product terms from the AND array
  input  wire logic [CELLS*NTERMS-1:0]   terms_i,
  // Dedicated pins (clock and enable pins in registered mode)
  input  wire logic                      ded_in_a_i,
  input  wire logic                      ded_in_b_i,
  // Macrocell pins
  input  wire logic [CELLS-1:0]          pin_i,
  output logic [CELLS-1:0]               pin_o,
  output logic [CELLS-1:0]               pin_oe_o,
  // Feedback into the AND array
  output logic [CELLS-1:0]               feedback_o,
  output logic                           ded_a_to_array_o,
  output logic                           ded_b_to_array_o,
  // Status
  output omc_pkg::omc_mode_type          mode_o,
  output logic                           config_error_o,
  output logic [7:0]                     signature_byte_o [8]
);
  typedef struct packed {
    logic [CELLS-1:0] pin;
    logic [CELLS-1:0] oe;
    logic [CELLS-1:0] fb;
    logic             da;
    logic             db;
    logic             err;
    logic [1:0]       mode;
  } omc_state_type;

  omc_state_type st;
  omc_state_type next_st;
  logic [CELLS-1:0] cell_d;
  logic [CELLS-1:0] cell_oe;
  logic [CELLS-1:0] is_input;
  omc_pkg::omc_mode_type mode;

  function automatic int count_ones(input logic [CELLS-1:0] v);
    int n;
    n = 0;
    for (int k = 0; k < CELLS; k++) begin
      n += int'(v[k]);
    end
    return n;
  endfunction : count_ones

  // Global mode decode; registered mode is out of scope and leaves pins off
  always_comb begin
    if (global_sync_select_bit_i) begin
      mode = omc_pkg::OMC_MODE_SIMPLE;
    end else if (global_arch_select_bit_i) begin
      mode = omc_pkg::OMC_MODE_COMPLEX;
    end else begin
      mode = omc_pkg::OMC_MODE_REGISTERED;
    end
  end

  // Centre cells can never be inputs in simple mode
  always_comb begin
    for (int c = 0; c < CELLS; c++) begin
      is_input[c] = cell_direction_bit_i[c];
      if (mode == omc_pkg::OMC_MODE_SIMPLE && (c == `OMC_CENTER_LO || c == `OMC_CENTER_HI)) begin
        is_input[c] = 1'b0;
      end
      if (mode == omc_pkg::OMC_MODE_COMPLEX) begin
        is_input[c] = 1'b0; // direction set by the enable term
      end
    end
  end

  for (genvar g = 0; g < CELLS; g++) begin : g_cell
    omc_cell #(.TERMS(NTERMS)) u_cell (
      .terms_i   (terms_i[g*NTERMS +: NTERMS]),
      .complex_i (mode == omc_pkg::OMC_MODE_COMPLEX),
      .polarity_i(polarity_i[g]),
      .oe_term_i (terms_i[g*NTERMS + NTERMS-1]),
      .is_input_i(is_input[g]),
      .data_o    (cell_d[g]),
      .oe_o      (cell_oe[g])
    );
  end

  always_comb begin
    next_st = st;
    next_st.mode = mode;
    next_st.pin = cell_d;
    next_st.oe = (mode == omc_pkg::OMC_MODE_REGISTERED) ? '0 : cell_oe;
    next_st.fb = '0;
    next_st.da = ded_in_a_i;
    next_st.db = ded_in_b_i;
    // Too many cells left free to float means more than six bidirectional pins
    next_st.err = (mode == omc_pkg::OMC_MODE_COMPLEX) &&
                  (count_ones(~cell_direction_bit_i) > `OMC_MAX_BIDIR);
    unique case (mode)
      omc_pkg::OMC_MODE_COMPLEX: begin
        for (int c = 0; c < CELLS; c++) begin
          next_st.fb[c] = pin_i[c];
        end
        // Outer paths carry the dedicated inputs instead
        next_st.fb[`OMC_OUTER_LO] = ded_in_b_i;
        next_st.fb[`OMC_OUTER_HI] = ded_in_a_i;
      end
      omc_pkg::OMC_MODE_SIMPLE: begin
        // Each half feeds back through its inner neighbour; centre cells lose feedback
        for (int c = 0; c < CELLS/2 - 1; c++) begin
          next_st.fb[c] = pin_i[c+1];
          next_st.fb[CELLS-1-c] = pin_i[CELLS-2-c];
        end
      end
      omc_pkg::OMC_MODE_REGISTERED: begin
        next_st.fb = '0;
      end
    endcase
  end

  // Registering every output except the signature bytes costs one cycle but keeps pin drive free of glitches
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_o            = st.pin;
  assign pin_oe_o         = st.oe;
  assign feedback_o       = st.fb;
  assign ded_a_to_array_o = st.da;
  assign ded_b_to_array_o = st.db;
  assign mode_o           = omc_pkg::omc_mode_type'(st.mode);
  assign config_error_o   = st.err;

  // Byte 0 holds the lowest fuse address of the signature
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      signature_byte_o[b] = user_signature_fuses_i[b*8 +: 8];
    end
  end

  // Every output but the signature bytes is registered, so each check looks one edge after its cause
  a_simple_always_on: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mode == omc_pkg::OMC_MODE_SIMPLE && !cell_direction_bit_i[0] |=> pin_oe_o[0])
    else $error("simple output not driven");
  a_simple_input: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mode == omc_pkg::OMC_MODE_SIMPLE && cell_direction_bit_i[1] |=> !pin_oe_o[1])
    else $error("simple input cell driven");
  a_center_outputs: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mode == omc_pkg::OMC_MODE_SIMPLE |=> pin_oe_o[`OMC_CENTER_LO] && pin_oe_o[`OMC_CENTER_HI])
    else $error("centre cell not output");
  a_outer_feedback: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mode == omc_pkg::OMC_MODE_COMPLEX |=> feedback_o[`OMC_OUTER_HI] == $past(ded_in_a_i))
    else $error("outer feedback wrong");
  a_outer_lo_feedback: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mode == omc_pkg::OMC_MODE_COMPLEX |=> feedback_o[`OMC_OUTER_LO] == $past(ded_in_b_i))
    else $error("low outer feedback wrong");
  a_oe_term: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mode == omc_pkg::OMC_MODE_COMPLEX |=> pin_oe_o[1] == $past(terms_i[2*NTERMS-1]))
    else $error("enable term not followed");
  a_oe_float: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mode == omc_pkg::OMC_MODE_COMPLEX && !terms_i[NTERMS-1] |=> !pin_oe_o[0])
    else $error("pin driven while enable false");
  a_complex_or: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mode == omc_pkg::OMC_MODE_COMPLEX && terms_i[NTERMS-2:0] == '0 |=> pin_o[0] == !$past(polarity_i[0]))
    else $error("complex sum wrong");
  a_simple_or: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mode == omc_pkg::OMC_MODE_SIMPLE && !polarity_i[2] && terms_i[3*NTERMS-1] |=> !pin_o[2])
    else $error("simple sum wrong");
  a_inner_nofb: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mode == omc_pkg::OMC_MODE_SIMPLE |=> feedback_o[`OMC_CENTER_LO] == 1'b0 && feedback_o[0] == $past(pin_i[1]))
    else $error("simple feedback wrong");
  a_ded_inputs: assert property (@(posedge clk_i) disable iff (!nrst_i)
    1'b1 |=> ded_a_to_array_o == $past(ded_in_a_i) && ded_b_to_array_o == $past(ded_in_b_i))
    else $error("dedicated input lost");
  a_bidir_limit: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mode == omc_pkg::OMC_MODE_COMPLEX && cell_direction_bit_i == '0 |=> config_error_o)
    else $error("bidirectional limit not flagged");
  a_bidir_allowed: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mode == omc_pkg::OMC_MODE_COMPLEX && cell_direction_bit_i[`OMC_OUTER_LO] &&
    cell_direction_bit_i[`OMC_OUTER_HI] |=> !config_error_o)
    else $error("legal bidirectional count flagged");
  a_mode_simple: assert property (@(posedge clk_i) disable iff (!nrst_i)
    global_sync_select_bit_i |=> mode_o == omc_pkg::OMC_MODE_SIMPLE)
    else $error("simple mode not selected");
  a_registered_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !global_sync_select_bit_i && !global_arch_select_bit_i |=> pin_oe_o == '0)
    else $error("pin driven in registered mode");

  c_simple: cover property (@(posedge clk_i) mode_o == omc_pkg::OMC_MODE_SIMPLE && pin_oe_o != '0);
  c_simple_input: cover property (@(posedge clk_i) mode_o == omc_pkg::OMC_MODE_SIMPLE && !pin_oe_o[1]);
  c_complex_off: cover property (@(posedge clk_i) mode_o == omc_pkg::OMC_MODE_COMPLEX && !pin_oe_o[2]);
  c_complex_on: cover property (@(posedge clk_i) mode_o == omc_pkg::OMC_MODE_COMPLEX && pin_oe_o[2]);
  c_bidir_error: cover property (@(posedge clk_i) mode_o == omc_pkg::OMC_MODE_COMPLEX && config_error_o);
endmodule : omc_array

/* hdl/omc_regs.svh */
// Constants for the output macrocell array: sizes, cell positions, fuse map.
// Included by the package user files; holds definitions only.
`ifndef OMC_REGS_SVH
`define OMC_REGS_SVH
`define OMC_CELLS          8
`define OMC_ARRAY_INPUTS   32
`define OMC_TERMS_SIMPLE   8
`define OMC_TERMS_COMPLEX  7
`define OMC_MAX_BIDIR      6
`define OMC_SIG_BITS       64
`define OMC_SIG_FIRST_FUSE 2056
`define OMC_SIG_LAST_FUSE  2119
`define OMC_OUTER_LO       0
`define OMC_OUTER_HI       7
`define OMC_CENTER_LO      3
`define OMC_CENTER_HI      4
`endif

/* hdl/omc_pkg.sv */
// Types shared by the output macrocell array.
// Assumes users name every item with the package prefix.
package omc_pkg;
  typedef enum logic [1:0] {
    OMC_MODE_SIMPLE,
    OMC_MODE_COMPLEX,
    OMC_MODE_REGISTERED
  } omc_mode_type;
endpackage : omc_pkg

/* hdl/omc_cell.sv */
// One output macrocell: OR of product terms, polarity, enable term.
// Assumes the product terms arrive already evaluated by the AND array.
`timescale 1ns/100ps
`include "omc_regs.svh"
module omc_cell #(
  parameter int TERMS = `OMC_TERMS_SIMPLE
) (
  // Product terms and configuration
  input  wire logic [TERMS-1:0] terms_i,
  input  wire logic             complex_i,
  input  wire logic             polarity_i,
  input  wire logic             oe_term_i,
  input  wire logic             is_input_i,
  // Pin drive
  output logic                  data_o,
  output logic                  oe_o
);
  logic sum;
  always_comb begin
    // Complex mode gives up the last term to the enable
    if (complex_i) begin
      sum = |terms_i[TERMS-2:0];
    end else begin
      sum = |terms_i;
    end
  end
  assign data_o = polarity_i ? sum : ~sum;
  // Simple outputs drive always; complex follows the enable term; off means high impedance
  assign oe_o = is_input_i ? 1'b0 : (complex_i ? oe_term_i : 1'b1);
endmodule : omc_cell

/* tb/omc_board.sv */
// Board model at the macrocell pins: resolves each pin wire.
// Assumes the array drives a pin only while its enable is high.
`timescale 1ns/100ps
module omc_board (
  // Array side
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] pin_oe_i,
  // Board drivers
  input  wire logic [7:0] ext_val_i,
  input  wire logic [7:0] ext_en_i,
  // Level seen by the array
  output logic      [7:0] wire_o
);
  // A pin left by both sides floats up through the pull-up
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      wire_o[c] = pin_oe_i[c] ? pin_o_i[c] : (ext_en_i[c] ? ext_val_i[c] : 1'b1);
    end
  end
endmodule : omc_board

/* tb/testbench.sv */
// Bench for the macrocell array: random configurations, checked one edge later, signature bytes at once.
// Assumes the board model closes the pin loop; inputs move on falling edges.
`timescale 1ns/100ps
module testbench;
  logic        clk_i = 0, nrst_i = 0, sy = 0, ar = 0, da = 0, db = 0;
  logic [7:0]  pol = 0, dir = 0, ev = 0, ee = 0, pin_i, pin_o, oe, fb, sb [8];
  logic [63:0] sig = 0, tm = 0, tclr = 0;
  logic        dao, dbo, cfe, x_err, x_da, x_db;
  logic [7:0]  x_o, x_oe, x_fb;
  logic [31:0] rs = 32'hd9baff14;
  int          fails = 0, n_compared = 0;
  omc_pkg::omc_mode_type md, x_md;
  omc_array i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .global_sync_select_bit_i(sy),
    .global_arch_select_bit_i(ar), .polarity_i(pol), .cell_direction_bit_i(dir),
    .user_signature_fuses_i(sig), .terms_i(tm), .ded_in_a_i(da), .ded_in_b_i(db),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(oe), .feedback_o(fb), .ded_a_to_array_o(dao),
    .ded_b_to_array_o(dbo), .mode_o(md), .config_error_o(cfe), .signature_byte_o(sb));
  omc_board i_board (.pin_o_i(pin_o), .pin_oe_i(oe), .ext_val_i(ev), .ext_en_i(ee), .wire_o(pin_i));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : nx
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Expectation is taken from inputs and pin levels just before the sampling edge
  task automatic predict();
    int nb;
    logic s;
    nb = 0;
    x_md = sy ? omc_pkg::OMC_MODE_SIMPLE : (ar ? omc_pkg::OMC_MODE_COMPLEX : omc_pkg::OMC_MODE_REGISTERED);
    for (int c = 0; c < 8; c++) begin
      s = sy ? |tm[8*c +: 8] : |tm[8*c +: 7];
      x_o[c] = s ~^ pol[c];
      x_oe[c] = sy ? (~dir[c] | (c == 3) | (c == 4)) : (ar & tm[8*c+7]);
      nb += (dir[c] == 1'b0);
    end
    x_fb = sy ? {pin_i[6:4], 2'b00, pin_i[3:1]} : (ar ? {da, pin_i[6:1], db} : 8'h00);
    x_err = nb > 6;
    x_da = da;
    x_db = db;
  endtask : predict
  task automatic cyc(input logic s, input logic a, input logic [7:0] d);
    @(negedge clk_i);
    sy = s;
    ar = a;
    dir = d;
    rs = nx(rs);
    tm[31:0] = rs;
    rs = nx(rs);
    tm[63:32] = rs;
    rs = nx(rs);
    {pol, ev, ee, da, db} = rs[25:0];
    sig = {tm[31:0], rs};
    tm = tm & ~tclr;
    #1;
    predict();
    for (int b = 0; b < 8; b++) check(sb[b], sig[8*b +: 8], "signature");
    @(negedge clk_i);
    check({6'h00, md}, {6'h00, x_md}, "mode");
    check(oe, x_oe, "enable");
    check(pin_o & x_oe, x_o & x_oe, "data");
    check(fb, x_fb, "feedback");
    if (x_md == omc_pkg::OMC_MODE_COMPLEX) check({7'h00, cfe}, {7'h00, x_err}, "bidir count");
    if (x_md != omc_pkg::OMC_MODE_REGISTERED) check({6'h00, dao, dbo}, {6'h00, x_da, x_db}, "ded");
  endtask : cyc
  initial begin
    #20us;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (12) @(negedge clk_i);
    check(oe, 8'h00, "reset enable");
    nrst_i = 1;
    // Seven bidirectional cells must be flagged, six must not
    cyc(1'b0, 1'b1, 8'h01);
    cyc(1'b0, 1'b1, 8'h81);
    cyc(1'b1, 1'b0, 8'hff);
    cyc(1'b1, 1'b1, 8'h00);
    cyc(1'b0, 1'b0, 8'h00);
    // Cell 0 with every term cleared, all cells bidirectional candidates
    tclr = 64'h0000_0000_0000_00ff;
    cyc(1'b0, 1'b1, 8'h00);
    cyc(1'b1, 1'b0, 8'h00);
    tclr = 64'h0000_0000_0000_0000;
    for (int i = 0; i < 300; i++) begin
      rs = nx(rs);
      cyc(rs[0], rs[1], rs[9:2]);
      if (i == 150) begin
        @(negedge clk_i);
        nrst_i = 0;
        @(negedge clk_i);
        check(oe, 8'h00, "mid-run reset enable");
        nrst_i = 1;
      end
    end
    wrap_up();
  end
endmodule : testbench
